/* File: hdl/irq_ctrl_pkg.sv */
// Package: register map, bit positions, vectors and types of the controller
package irq_ctrl_pkg;

	// Register indexes on the plain register port
	localparam logic [2:0] ADDR_EDGE_SEL = 3'h0;
	localparam logic [2:0] ADDR_CTRL0    = 3'h1;
	localparam logic [2:0] ADDR_CTRL1    = 3'h2;
	localparam logic [2:0] ADDR_GRP0     = 3'h3;
	localparam logic [2:0] ADDR_GRP1     = 3'h4;
	localparam logic [2:0] ADDR_STATUS   = 3'h5;

	localparam logic [7:0] REG_RESET = 8'h00;

	// Control register 0 bit positions
	localparam int C0_TB1_F = 6;
	localparam int C0_TB0_F = 5;
	localparam int C0_EXTF  = 4;
	localparam int C0_TB1_E = 3;
	localparam int C0_TB0_E = 2;
	localparam int C0_EXTE  = 1;
	localparam int C0_GIE   = 0;

	// Control register 1 bit positions
	localparam int C1_G1F    = 7;
	localparam int C1_CONV_F = 6;
	localparam int C1_EEF    = 5;
	localparam int C1_G0F    = 4;
	localparam int C1_G1E    = 3;
	localparam int C1_CONV_E = 2;
	localparam int C1_EEE    = 1;
	localparam int C1_G0E    = 0;

	// Group register bit positions
	localparam int GR_AF = 5;
	localparam int GR_PF = 4;
	localparam int GR_AE = 1;
	localparam int GR_PE = 0;

	// Edge-select codes
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Source index, in priority order, highest first
	localparam int NSRC    = 7;
	localparam int SRC_EXT = 0;
	localparam int SRC_TB0 = 1;
	localparam int SRC_TB1 = 2;
	localparam int SRC_G0  = 3;
	localparam int SRC_AD  = 4;
	localparam int SRC_EE  = 5;
	localparam int SRC_G1  = 6;

	localparam int PC_W = 12;

	// Vector addresses, plain defaults
	localparam logic [PC_W-1:0] VEC_EXT = 12'h004;
	localparam logic [PC_W-1:0] VEC_TB0 = 12'h008;
	localparam logic [PC_W-1:0] VEC_TB1 = 12'h00C;
	localparam logic [PC_W-1:0] VEC_G0  = 12'h010;
	localparam logic [PC_W-1:0] VEC_AD  = 12'h014;
	localparam logic [PC_W-1:0] VEC_EE  = 12'h018;
	localparam logic [PC_W-1:0] VEC_G1  = 12'h01C;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	// Event pulses from peripherals
	typedef struct packed {
		logic tb0;
		logic tb1;
		logic ad;
		logic ee;
		logic t0a;
		logic t0p;
		logic t1a;
		logic t1p;
	} src_evt_type;

	// Request towards the CPU sequencer
	typedef struct packed {
		logic            req;
		logic [PC_W-1:0] vector;
		logic [PC_W-1:0] push_pc;
	} cpu_call_type;

endpackage

/* File: hdl/irq_ctrl.sv */
// Interrupt controller: flags, enables, priority, call and return control
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module irq_ctrl
	import irq_ctrl_pkg::*;
(
	input  wire logic         ref_clk,     // System clock, 10 MHz
	input  wire logic         srst,        // Synchronous reset
	input  wire reg_req_type  bus_req,     // Register access
	output logic [7:0]        rdata,       // Read data, cycle after read
	input  wire logic         ext_pin,     // External interrupt pin
	input  wire src_evt_type  src_evt,     // Peripheral event pulses
	input  wire logic         stack_full,  // CPU stack is full
	input  wire logic         call_ack,    // CPU performed the call
	input  wire logic         reti,        // Return instruction executed
	input  wire logic [PC_W-1:0] next_pc,  // Address of next instruction
	input  wire logic [PC_W-1:0] pop_pc,   // Address popped from stack
	output cpu_call_type      call,        // Call request to CPU
	output logic              pc_load,     // Load program counter
	output logic [PC_W-1:0]   pc_value,    // Value to load
	output logic              wake         // Wake-up pulse
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALL = 2'b01
	} seq_type;

	// Lowest set index wins
	function automatic logic [2:0] pick(input logic [NSRC-1:0] v);
		logic [2:0] r;
		r = 3'h7;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [PC_W-1:0] vec_of(input logic [2:0] s);
		logic [PC_W-1:0] v;
		case (s)
			3'(SRC_EXT): v = VEC_EXT;
			3'(SRC_TB0): v = VEC_TB0;
			3'(SRC_TB1): v = VEC_TB1;
			3'(SRC_G0):  v = VEC_G0;
			3'(SRC_AD):  v = VEC_AD;
			3'(SRC_EE):  v = VEC_EE;
			default:     v = VEC_G1;
		endcase
		return v;
	endfunction

	logic [1:0]      edge_sel_r;
	logic [7:0]      ctrl0_r;
	logic [7:0]      ctrl1_r;
	logic [7:0]      grp0_r;
	logic [7:0]      grp1_r;
	logic            pin_s1_r;
	logic            pin_s2_r;
	logic            pin_d_r;
	seq_type         seq_r;
	logic [2:0]      sel_r;
	logic [NSRC-1:0] flags;
	logic [NSRC-1:0] flags_d_r;
	logic [3:0]      tflags;
	logic [3:0]      tflags_d_r;
	logic [NSRC-1:0] enab;
	logic [NSRC-1:0] pend;
	logic            ext_hit;
	logic            g0_rise;
	logic            g1_rise;
	logic            accept;
	logic [2:0]      win;
	logic            wr0;
	logic            wr1;
	logic            wrg0;
	logic            wrg1;
	logic            svc;

	assign wr0  = bus_req.wr && bus_req.addr == ADDR_CTRL0;
	assign wr1  = bus_req.wr && bus_req.addr == ADDR_CTRL1;
	assign wrg0 = bus_req.wr && bus_req.addr == ADDR_GRP0;
	assign wrg1 = bus_req.wr && bus_req.addr == ADDR_GRP1;

	// Pin synchroniser and edge detection
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_d_r  <= 1'b0;
		end else begin
			pin_s1_r <= ext_pin;
			pin_s2_r <= pin_s1_r;
			pin_d_r  <= pin_s2_r;
		end
	end

	always_comb begin
		case (edge_sel_r)
			EDGE_RISE: ext_hit = pin_s2_r && !pin_d_r;
			EDGE_FALL: ext_hit = !pin_s2_r && pin_d_r;
			EDGE_BOTH: ext_hit = pin_s2_r != pin_d_r;
			default:   ext_hit = 1'b0;
		endcase
	end

	assign flags = {ctrl1_r[C1_G1F], ctrl1_r[C1_EEF], ctrl1_r[C1_CONV_F],
	                ctrl1_r[C1_G0F], ctrl0_r[C0_TB1_F], ctrl0_r[C0_TB0_F],
	                ctrl0_r[C0_EXTF]};
	assign enab  = {ctrl1_r[C1_G1E], ctrl1_r[C1_EEE], ctrl1_r[C1_CONV_E],
	                ctrl1_r[C1_G0E], ctrl0_r[C0_TB1_E], ctrl0_r[C0_TB0_E],
	                ctrl0_r[C0_EXTE]};
	assign pend  = flags & enab;
	assign win   = pick(pend);
	assign accept = seq_r == ST_IDLE && ctrl0_r[C0_GIE] && |pend
	                && !stack_full;
	assign svc    = seq_r == ST_CALL && call_ack;

	// Group registers: timer flags only cleared by software
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			grp0_r <= REG_RESET;
			grp1_r <= REG_RESET;
		end else begin
			if (wrg0) begin
				grp0_r[GR_AF] <= bus_req.wdata[GR_AF];
				grp0_r[GR_PF] <= bus_req.wdata[GR_PF];
				grp0_r[GR_AE] <= bus_req.wdata[GR_AE];
				grp0_r[GR_PE] <= bus_req.wdata[GR_PE];
			end
			if (wrg1) begin
				grp1_r[GR_AF] <= bus_req.wdata[GR_AF];
				grp1_r[GR_PF] <= bus_req.wdata[GR_PF];
				grp1_r[GR_AE] <= bus_req.wdata[GR_AE];
				grp1_r[GR_PE] <= bus_req.wdata[GR_PE];
			end
			// Set wins over clear; service never clears these
			if (src_evt.t0a) grp0_r[GR_AF] <= 1'b1;
			if (src_evt.t0p) grp0_r[GR_PF] <= 1'b1;
			if (src_evt.t1a) grp1_r[GR_AF] <= 1'b1;
			if (src_evt.t1p) grp1_r[GR_PF] <= 1'b1;
		end
	end

	// A timer flag rising, gated by its own enable, feeds its group
	assign g0_rise = (src_evt.t0a && grp0_r[GR_AE] && !grp0_r[GR_AF])
	              || (src_evt.t0p && grp0_r[GR_PE] && !grp0_r[GR_PF]);
	assign g1_rise = (src_evt.t1a && grp1_r[GR_AE] && !grp1_r[GR_AF])
	              || (src_evt.t1p && grp1_r[GR_PE] && !grp1_r[GR_PF]);

	// Timer flags wake the device too, whatever their enables
	assign tflags = {grp1_r[GR_AF], grp1_r[GR_PF], grp0_r[GR_AF],
	                 grp0_r[GR_PF]};

	// Control register 0
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl0_r    <= REG_RESET;
			edge_sel_r <= EDGE_OFF;
		end else begin
			if (bus_req.wr && bus_req.addr == ADDR_EDGE_SEL) begin
				edge_sel_r <= bus_req.wdata[1:0];
			end
			if (wr0) begin
				ctrl0_r <= {1'b0, bus_req.wdata[6:0]};
			end
			if (accept) begin
				ctrl0_r[C0_GIE] <= 1'b0;
			end
			if (svc && sel_r == 3'(SRC_EXT)) ctrl0_r[C0_EXTF] <= 1'b0;
			if (svc && sel_r == 3'(SRC_TB0)) ctrl0_r[C0_TB0_F] <= 1'b0;
			if (svc && sel_r == 3'(SRC_TB1)) ctrl0_r[C0_TB1_F] <= 1'b0;
			if (ext_hit)     ctrl0_r[C0_EXTF] <= 1'b1;
			if (src_evt.tb0) ctrl0_r[C0_TB0_F] <= 1'b1;
			if (src_evt.tb1) ctrl0_r[C0_TB1_F] <= 1'b1;
		end
	end

	// Control register 1
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl1_r <= REG_RESET;
		end else begin
			if (wr1) begin
				ctrl1_r <= bus_req.wdata;
			end
			if (svc && sel_r == 3'(SRC_G0)) ctrl1_r[C1_G0F] <= 1'b0;
			if (svc && sel_r == 3'(SRC_AD)) ctrl1_r[C1_CONV_F] <= 1'b0;
			if (svc && sel_r == 3'(SRC_EE)) ctrl1_r[C1_EEF] <= 1'b0;
			if (svc && sel_r == 3'(SRC_G1)) ctrl1_r[C1_G1F] <= 1'b0;
			if (src_evt.ad) ctrl1_r[C1_CONV_F] <= 1'b1;
			if (src_evt.ee) ctrl1_r[C1_EEF] <= 1'b1;
			if (g0_rise)    ctrl1_r[C1_G0F] <= 1'b1;
			if (g1_rise)    ctrl1_r[C1_G1F] <= 1'b1;
		end
	end

	// Call sequencer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			seq_r        <= ST_IDLE;
			sel_r        <= 3'h0;
			call         <= '0;
		end else begin
			case (seq_r)
				ST_IDLE: begin
					if (accept) begin
						seq_r        <= ST_CALL;
						sel_r        <= win;
						call.req     <= 1'b1;
						call.vector  <= vec_of(win);
						call.push_pc <= next_pc;
					end
				end
				ST_CALL: begin
					if (call_ack) begin
						seq_r    <= ST_IDLE;
						call.req <= 1'b0;
					end
				end
				default: begin
					seq_r    <= ST_IDLE;
					call.req <= 1'b0;
				end
			endcase
		end
	end

	// Program counter load on call and return
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pc_load  <= 1'b0;
			pc_value <= '0;
		end else begin
			pc_load <= svc || reti;
			if (svc) begin
				pc_value <= call.vector;
			end else if (reti) begin
				pc_value <= pop_pc;
			end
		end
	end

	// Wake on any flag low-to-high
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flags_d_r  <= '0;
			tflags_d_r <= '0;
			wake       <= 1'b0;
		end else begin
			flags_d_r  <= flags;
			tflags_d_r <= tflags;
			wake       <= |(flags & ~flags_d_r)
			              || |(tflags & ~tflags_d_r);
		end
	end

	// Read port
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata <= REG_RESET;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				ADDR_EDGE_SEL: rdata <= {6'h00, edge_sel_r};
				ADDR_CTRL0:    rdata <= ctrl0_r;
				ADDR_CTRL1:    rdata <= ctrl1_r;
				ADDR_GRP0:     rdata <= grp0_r;
				ADDR_GRP1:     rdata <= grp1_r;
				ADDR_STATUS:   rdata <= {4'h0, seq_r == ST_CALL, sel_r};
				default:       rdata <= REG_RESET;
			endcase
		end else begin
			rdata <= REG_RESET;
		end
	end

	property p_no_take_without_gie;
		@(posedge ref_clk) disable iff (srst)
		(seq_r == ST_IDLE && !ctrl0_r[C0_GIE]) |=> !call.req;
	endproperty
	a_no_take_without_gie: assert property (p_no_take_without_gie)
		else $error("call raised with global enable clear");

	property p_no_take_stack_full;
		@(posedge ref_clk) disable iff (srst)
		(seq_r == ST_IDLE && stack_full) |=> !call.req;
	endproperty
	a_no_take_stack_full: assert property (p_no_take_stack_full)
		else $error("call raised while stack full");

	property p_gie_cleared;
		@(posedge ref_clk) disable iff (srst)
		$rose(call.req) |-> !ctrl0_r[C0_GIE];
	endproperty
	a_gie_cleared: assert property (p_gie_cleared)
		else $error("global enable not cleared on entry");

	property p_enabled_only;
		@(posedge ref_clk) disable iff (srst)
		accept |-> enab[win] && flags[win];
	endproperty
	a_enabled_only: assert property (p_enabled_only)
		else $error("selected source not enabled");

	property p_priority;
		@(posedge ref_clk) disable iff (srst)
		(accept && pend[SRC_EXT]) |=> sel_r == 3'(SRC_EXT);
	endproperty
	a_priority: assert property (p_priority)
		else $error("pin request lost priority");

	property p_vector_load;
		@(posedge ref_clk) disable iff (srst)
		(svc && !reti) |=> pc_load && pc_value == $past(call.vector);
	endproperty
	a_vector_load: assert property (p_vector_load)
		else $error("vector not loaded after call");

	property p_return;
		@(posedge ref_clk) disable iff (srst)
		(reti && !svc) |=> pc_load && pc_value == $past(pop_pc);
	endproperty
	a_return: assert property (p_return)
		else $error("return address not loaded");

	property p_ext_cleared;
		@(posedge ref_clk) disable iff (srst)
		(svc && sel_r == 3'(SRC_EXT) && !ext_hit && !wr0)
		|=> !ctrl0_r[C0_EXTF];
	endproperty
	a_ext_cleared: assert property (p_ext_cleared)
		else $error("pin flag not cleared on service");

	property p_group_cleared;
		@(posedge ref_clk) disable iff (srst)
		(svc && sel_r == 3'(SRC_G0) && !g0_rise && !wr1)
		|=> !ctrl1_r[C1_G0F];
	endproperty
	a_group_cleared: assert property (p_group_cleared)
		else $error("group flag not cleared on service");

	property p_flag_sets;
		@(posedge ref_clk) disable iff (srst)
		src_evt.ad |=> ctrl1_r[C1_CONV_F];
	endproperty
	a_flag_sets: assert property (p_flag_sets)
		else $error("converter flag not set by event");

	property p_wake;
		@(posedge ref_clk) disable iff (srst)
		(|(flags & ~flags_d_r) || |(tflags & ~tflags_d_r)) |=> wake;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake on rising flag");

endmodule // irq_ctrl

/* File: sim/cpu_seq_model.sv */
// CPU sequencer model that takes calls and returns from them
`timescale 1ns/10ps
module cpu_seq_model
	import irq_ctrl_pkg::*;
(
	input  wire logic         ref_clk,  // System clock
	input  wire logic         srst,     // Sync reset
	input  wire cpu_call_type call,     // Call request
	input  wire logic [1:0]   ack_dly,  // Wait before ack
	output logic              call_ack, // Call done
	output logic              reti,     // Return done
	output logic [PC_W-1:0]   pop_pc,   // Popped address
	output int                acks,     // Calls taken
	output int                rets      // Returns made
);
	logic [PC_W-1:0] saved_r;
	int              wait_r;
	int              ret_r;

	always_ff @(posedge ref_clk) begin
		call_ack <= 1'b0;
		reti     <= 1'b0;
		// Stack output does not hold its value between returns
		pop_pc   <= ~saved_r;
		if (srst) begin
			wait_r  <= 0;
			ret_r   <= 0;
			acks    <= 0;
			rets    <= 0;
			saved_r <= '0;
		end else if (call.req && !call_ack) begin
			if (wait_r == int'(ack_dly)) begin
				call_ack <= 1'b1;
				saved_r  <= call.push_pc;
				acks     <= acks + 1;
				wait_r   <= 0;
				ret_r    <= 8;
			end else begin
				wait_r <= wait_r + 1;
			end
		end else if (ret_r == 1) begin
			reti   <= 1'b1;
			pop_pc <= saved_r;
			rets   <= rets + 1;
			ret_r  <= 0;
		end else if (ret_r > 1) begin
			ret_r <= ret_r - 1;
		end
	end
endmodule // cpu_seq_model

/* File: sim/tb_mcu_interrupt_controller.sv */
// Testbench of the interrupt controller
`timescale 1ns/10ps
module tb_mcu_interrupt_controller
	import irq_ctrl_pkg::*;
;
	typedef struct packed {
		logic [2:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} row_type;

	logic            ref_clk    = 1'b0;
	logic            srst       = 1'b1;
	reg_req_type     bus_req    = '0;
	logic            ext_pin    = 1'b0;
	src_evt_type     src_evt    = '0;
	logic            stack_full = 1'b0;
	logic [PC_W-1:0] next_pc    = 12'h0a5;
	logic [1:0]      ack_dly    = 2'h0;
	logic [7:0]      rdata;
	logic            call_ack;
	logic            reti;
	logic            pc_load;
	logic            wake;
	logic [PC_W-1:0] pop_pc;
	logic [PC_W-1:0] pc_value;
	cpu_call_type    call;
	logic [2:0]      tbf;
	logic [PC_W-1:0] loads[$];
	int              acks;
	int              rets;
	int              wc;
	int              failures = 0;
	int              checked  = 0;
	int              cycles   = 0;
	int              wakes    = 0;
	row_type         rows[12] = '{
		'{ADDR_EDGE_SEL, 8'hff, 8'h03}, '{ADDR_CTRL0, 8'hfe, 8'h7e},
		'{ADDR_GRP0, 8'hff, 8'h33}, '{ADDR_GRP1, 8'hff, 8'h33},
		'{ADDR_CTRL1, 8'hff, 8'hff}, '{3'h6, 8'hff, 8'h00},
		'{3'h7, 8'hff, 8'h00}, '{ADDR_GRP0, 8'h00, 8'h00},
		'{ADDR_GRP1, 8'h00, 8'h00}, '{ADDR_CTRL1, 8'h00, 8'h00},
		'{ADDR_CTRL0, 8'h00, 8'h00}, '{ADDR_EDGE_SEL, 8'h00, 8'h00}
	};
	logic [PC_W-1:0] vecs[6] = '{VEC_EXT, VEC_TB0, VEC_TB1,
		VEC_G0, VEC_EE, VEC_G1};

	irq_ctrl dut (.ref_clk, .srst, .bus_req, .rdata, .ext_pin,
		.src_evt, .stack_full, .call_ack, .reti, .next_pc, .pop_pc,
		.call, .pc_load, .pc_value, .wake);

	cpu_seq_model cpu (.ref_clk, .srst, .call, .ack_dly, .call_ack,
		.reti, .pop_pc, .acks, .rets);

	always #50 ref_clk = ~ref_clk;

	task automatic conclude();
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		bus_req <= '0;
		#1 chk("rdata", 16'(rdata), 16'(e));
	endtask

	// Wake pulses, program counter loads and the run ceiling
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (wake === 1'b1)
			wakes <= wakes + 1;
		if (pc_load === 1'b1)
			loads.push_back(pc_value);
		if (cycles == 5000) begin
			failures++;
			conclude();
		end
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		for (int a = 0; a < 8; a++)
			rd(3'(a), 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		// Every edge code, one rise and one fall each
		wc = wakes;
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_EDGE_SEL, {6'h00, 2'(c)});
			@(posedge ref_clk) ext_pin <= 1'b1;
			repeat (6) @(posedge ref_clk);
			rd(ADDR_CTRL0, {3'h0, c[0], 4'h0});
			wr(ADDR_CTRL0, 8'h00);
			@(posedge ref_clk) ext_pin <= 1'b0;
			repeat (6) @(posedge ref_clk);
			rd(ADDR_CTRL0, {3'h0, c[1], 4'h0});
			wr(ADDR_CTRL0, 8'h00);
		end
		repeat (3) @(posedge ref_clk);
		chk("wakes", 16'(wakes - wc), 16'h0004);
		// All sources at once, converter left disabled
		wr(ADDR_EDGE_SEL, 8'h01);
		wr(ADDR_CTRL1, 8'h0b);
		wr(ADDR_GRP0, 8'h03);
		wr(ADDR_GRP1, 8'h03);
		wr(ADDR_CTRL0, 8'h0e);
		@(posedge ref_clk) begin
			ext_pin <= 1'b1;
			src_evt <= '1;
		end
		@(posedge ref_clk) src_evt <= '0;
		repeat (8) @(posedge ref_clk);
		rd(ADDR_CTRL0, 8'h7e);
		rd(ADDR_CTRL1, 8'hfb);
		rd(ADDR_GRP0, 8'h33);
		rd(ADDR_GRP1, 8'h33);
		chk("acks", 16'(acks), 16'h0000);
		tbf = 3'h7;
		for (int i = 0; i < 6; i++) begin
			ack_dly <= 2'(i % 3);
			next_pc <= 12'h0a5 + 12'(i);
			stack_full <= (i == 0);
			wr(ADDR_CTRL0, {1'b0, tbf, 4'hf});
			if (i == 0) begin
				repeat (10) @(posedge ref_clk);
				chk("acks", 16'(acks), 16'h0000);
				stack_full <= 1'b0;
			end
			for (int t = 0; t < 20 && acks == i; t++)
				@(posedge ref_clk);
			if (i < 3)
				tbf[i] = 1'b0;
			rd(ADDR_CTRL0, {1'b0, tbf, 4'he});
			for (int t = 0; t < 20 && rets == i; t++)
				@(posedge ref_clk);
			repeat (3) @(posedge ref_clk);
			chk("vector", 16'(loads.pop_front()), 16'(vecs[i]));
			chk("return", 16'(loads.pop_front()), 16'(next_pc));
		end
		rd(ADDR_CTRL1, 8'h4b);
		rd(ADDR_GRP0, 8'h33);
		rd(ADDR_GRP1, 8'h33);
		wr(ADDR_CTRL0, 8'h0f);
		repeat (10) @(posedge ref_clk);
		chk("acks", 16'(acks), 16'h0006);
		wr(ADDR_GRP0, 8'h00);
		rd(ADDR_GRP0, 8'h00);
		// Second reset in mid-run
		@(posedge ref_clk) srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		rd(ADDR_CTRL0, 8'h00);
		rd(ADDR_CTRL1, 8'h00);
		rd(ADDR_GRP1, 8'h00);
		// Timer flag with its enable off: wakes, group flag stays clear
		wc = wakes;
		@(posedge ref_clk) src_evt.t1a <= 1'b1;
		@(posedge ref_clk) src_evt <= '0;
		repeat (3) @(posedge ref_clk);
		chk("wakes", 16'(wakes - wc), 16'h0001);
		rd(ADDR_GRP1, 8'h20);
		rd(ADDR_CTRL1, 8'h00);
		conclude();
	end
endmodule // tb_mcu_interrupt_controller
